// ---- logic/cmd_byte_decoder.sv ----
// Command byte decoder for a delta-sigma converter's three-wire serial port.
// Assumes a link-domain reset released with the core reset, and that the host
// keeps the link clock running for whole bytes.
`timescale 1ns/1ps
`include "cmd_decode_regs.svh"

// Function
// - Top bit 1 means conversion or calibration; 0 means register access only.
// - Multi flag 0 gives one settled conversion; 1 converts continuously.
// - Three-bit setup pointer picks one of eight stored setups, 000 to 111.
// - Every conversion takes its parameters from the pointed setup.
// - Array flag, channel 00, select 001 walks all offset registers; bit 3 sets direction.
// - After reset the first eight bits shifted in form the command byte.
// - Fifteen or more fill bytes then an end byte return to command mode anytime.
module cmd_byte_decoder
	import cmd_decode_pkg::*;
(
	input  wire logic        clk_in,         // Core clock, 250 MHz.
	input  wire logic        nrst_in,        // Synchronous reset, active low.
	input  wire logic        sclk_in,        // Serial link clock.
	input  wire logic        sdi_in,         // Serial data input.
	input  wire logic        data_done_in,   // Core finished the data phase of a register access.
	input  wire logic        conv_done_in,   // Core finished the started conversion or calibration.
	output logic      [7:0]  cmd_byte_out,   // Last command byte accepted.
	output logic             cmd_valid_out,  // One-cycle pulse on a decoded command.
	output op_kind_t         op_kind_out,    // Class of the last command.
	output logic      [2:0]  op_code_out,    // Conversion or calibration code.
	output logic             multi_out,      // Continuous conversion requested.
	output logic      [2:0]  setup_ptr_out,  // Selected stored setup.
	output logic      [1:0]  chan_sel_out,   // Channel select of a register access.
	output logic      [2:0]  reg_sel_out,    // Register select of a register access.
	output logic             read_out,       // Register access reads when high.
	output logic             array_out,      // Register access walks all channels.
	output logic             offset_array_out, // Array walk of all offset registers.
	output logic             cmd_mode_out,   // Port waits for a command byte.
	output logic             converting_out  // A conversion or calibration runs.
);
	byte_link_if lnk ();

	serial_byte_shifter u_shift (
		.sclk_in (sclk_in),
		.nrst_in (nrst_in),
		.sdi_in  (sdi_in),
		.lnk     (lnk)
	);

	// Toggles and byte value cross by two flops; the byte is stable for
	// eight link clocks after its toggle, far longer than the sync delay.
	// The byte toggle takes one extra flop so that the value is read a full
	// core clock after the toggle was caught, even with skew between the two.
	logic [2:0] btgl_sync_q;
	logic [1:0] rtgl_sync_q;
	logic       btgl_seen_q, rtgl_seen_q;
	logic [7:0] bval_resync_fill_byte_q, bval_sync2_q;
	logic       byte_evt, resync_evt;

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			btgl_sync_q  <= 3'h0;
			rtgl_sync_q  <= 2'h0;
			btgl_seen_q  <= 1'b0;
			rtgl_seen_q  <= 1'b0;
			bval_resync_fill_byte_q <= 8'h00;
			bval_sync2_q <= 8'h00;
		end else begin
			btgl_sync_q  <= {btgl_sync_q[1:0], lnk.byte_tgl};
			rtgl_sync_q  <= {rtgl_sync_q[0], lnk.resync_tgl};
			btgl_seen_q  <= btgl_sync_q[2];
			rtgl_seen_q  <= rtgl_sync_q[1];
			bval_resync_fill_byte_q <= lnk.byte_val;
			bval_sync2_q <= bval_resync_fill_byte_q;
		end
	end

	assign byte_evt   = btgl_sync_q[2] ^ btgl_seen_q;
	assign resync_evt = rtgl_sync_q[1] ^ rtgl_seen_q;

	function automatic logic op_code_legal(input logic [2:0] code);
		unique case (code)
			`OP_NORMAL, `OP_SELF_OFFSET, `OP_SELF_GAIN,
			`OP_SYS_OFFSET, `OP_SYS_GAIN: op_code_legal = 1'b1;
			default:                        op_code_legal = 1'b0;
		endcase
	endfunction

	link_state_t state_q, state_d;
	logic [7:0]  cmd_q, cmd_d;
	op_kind_t    kind_q, kind_d;
	logic        valid_q, valid_d;
	logic        conv_q, conv_d;
	logic        multi_q, multi_d;

	always_comb begin
		state_d = state_q;
		cmd_d   = cmd_q;
		kind_d  = kind_q;
		valid_d = 1'b0;
		conv_d  = conv_q;
		multi_d = multi_q;
		if (resync_evt) begin
			state_d = ST_COMMAND;
			conv_d  = 1'b0;
			multi_d = 1'b0;
		end else begin
			unique case (state_q)
				ST_COMMAND: begin
					if (byte_evt) begin
						// Fill bytes carry no command; they may precede a resync.
						if (bval_sync2_q != `RESYNC_FILL && bval_sync2_q != `RESYNC_END) begin
							cmd_d   = bval_sync2_q;
							valid_d = 1'b1;
							if (bval_sync2_q[`CMD_TYPE_BIT]) begin
								if (op_code_legal(bval_sync2_q[`CMD_REGSEL_HI:`CMD_REGSEL_LO])) begin
									kind_d  = (bval_sync2_q[`CMD_REGSEL_HI:`CMD_REGSEL_LO]
									           == `OP_NORMAL) ? OP_KIND_CONV : OP_KIND_CAL;
									multi_d = bval_sync2_q[`CMD_MULTI_BIT];
									conv_d  = 1'b1;
									state_d = bval_sync2_q[`CMD_MULTI_BIT] ? ST_CONT : ST_DATA;
								end else begin
									kind_d = OP_KIND_NONE;
								end
							end else begin
								kind_d  = bval_sync2_q[`CMD_ARRAY_BIT] ? OP_KIND_ARRAY
								                                         : OP_KIND_REG;
								state_d = ST_DATA;
							end
						end
					end
				end
				ST_DATA: begin
					if (conv_q ? conv_done_in : data_done_in) begin
						state_d = ST_COMMAND;
						conv_d  = 1'b0;
					end
				end
				ST_CONT: begin
					// Continuous mode runs until the host resyncs the port.
					conv_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_q <= ST_COMMAND;
			cmd_q   <= `CMD_RESET_VAL;
			kind_q  <= OP_KIND_NONE;
			valid_q <= 1'b0;
			conv_q  <= 1'b0;
			multi_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			kind_q  <= kind_d;
			valid_q <= valid_d;
			conv_q  <= conv_d;
			multi_q <= multi_d;
		end
	end

	assign cmd_byte_out     = cmd_q;
	assign cmd_valid_out    = valid_q;
	assign op_kind_out      = kind_q;
	assign op_code_out      = cmd_q[`CMD_REGSEL_HI:`CMD_REGSEL_LO];
	assign multi_out        = multi_q;
	assign setup_ptr_out    = cmd_q[`CMD_PTR_HI:`CMD_PTR_LO];
	assign chan_sel_out     = cmd_q[`CMD_CHAN_HI:`CMD_CHAN_LO];
	assign reg_sel_out      = cmd_q[`CMD_REGSEL_HI:`CMD_REGSEL_LO];
	assign read_out         = cmd_q[`CMD_RW_BIT];
	assign array_out        = (kind_q == OP_KIND_ARRAY);
	assign offset_array_out = (kind_q == OP_KIND_ARRAY)
	                          && (cmd_q[`CMD_CHAN_HI:`CMD_CHAN_LO] == 2'h0)
	                          && (cmd_q[`CMD_REGSEL_HI:`CMD_REGSEL_LO] == `REGSEL_OFFSET);
	assign cmd_mode_out     = (state_q == ST_COMMAND);
	assign converting_out   = conv_q;
endmodule

// ---- logic/cmd_decode_regs.svh ----
// Constants of the serial command byte decoder: field positions, codes, timing.
// Included by the design modules; holds definitions only.
`ifndef CMD_DECODE_REGS_SVH
`define CMD_DECODE_REGS_SVH

`define CMD_TYPE_BIT        7
`define CMD_ARRAY_BIT       6
`define CMD_MULTI_BIT       6
`define CMD_CHAN_HI         5
`define CMD_CHAN_LO         4
`define CMD_RW_BIT          3
`define CMD_PTR_HI          5
`define CMD_PTR_LO          3
`define CMD_REGSEL_HI       2
`define CMD_REGSEL_LO       0
`define CMD_RESET_VAL       8'h00
`define REGSEL_OFFSET       3'h1
`define REGSEL_GAIN         3'h2
`define REGSEL_CONFIG       3'h3
`define REGSEL_SETUP        3'h5
`define OP_NORMAL           3'h0
`define OP_SELF_OFFSET      3'h1
`define OP_SELF_GAIN        3'h2
`define OP_SYS_OFFSET       3'h5
`define OP_SYS_GAIN         3'h6
`define RESYNC_FILL         8'hff
`define RESYNC_END          8'hfe
`define RESYNC_MIN_FILLS    5'h0f
`define BITS_PER_BYTE       4'h8

`endif

// ---- logic/cmd_decode_pkg.sv ----
// Types shared by the command byte decoder modules.
// Assumes cmd_decode_regs.svh is on the include path.
package cmd_decode_pkg;
	typedef enum logic [2:0] {
		OP_KIND_NONE   = 3'h0,
		OP_KIND_CONV   = 3'h1,
		OP_KIND_CAL    = 3'h2,
		OP_KIND_REG    = 3'h3,
		OP_KIND_ARRAY  = 3'h4
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_COMMAND = 3'b001,
		ST_DATA    = 3'b010,
		ST_CONT    = 3'b100
	} link_state_t;
endpackage

// ---- logic/byte_link_if.sv ----
// Carrier between the link-side shifter and the core decoder.
// Assumes the producer toggles byte_tgl once per completed byte on the link clock.
`timescale 1ns/1ps
interface byte_link_if;
	logic       byte_tgl;
	logic [7:0] byte_val;
	logic       resync_tgl;
	modport link (output byte_tgl, output byte_val, output resync_tgl);
	modport core (input byte_tgl, input byte_val, input resync_tgl);
endinterface

// ---- logic/serial_byte_shifter.sv ----
// Link-clock shifter: assembles serial bits into bytes and spots the resync sequence.
// Assumes the serial clock is the link clock and data is valid on its rising edge.
`timescale 1ns/1ps
`include "cmd_decode_regs.svh"
module serial_byte_shifter
	import cmd_decode_pkg::*;
(
	input  wire logic  sclk_in,    // Link serial clock.
	input  wire logic  nrst_in,    // Synchronous reset, active low, link domain.
	input  wire logic  sdi_in,     // Serial data in.
	byte_link_if.link  lnk         // Bytes towards the core.
);
	logic [7:0] shift_q, shift_d;
	logic [3:0] cnt_q, cnt_d;
	logic [4:0] fills_q, fills_d;
	logic       tgl_q, tgl_d, rtgl_q, rtgl_d;
	logic [7:0] val_q, val_d;
	logic [7:0] nxt;

	always_comb begin
		nxt     = {shift_q[6:0], sdi_in};
		shift_d = nxt;
		cnt_d   = cnt_q + 4'h1;
		fills_d = fills_q;
		tgl_d   = tgl_q;
		rtgl_d  = rtgl_q;
		val_d   = val_q;
		if (cnt_q == `BITS_PER_BYTE - 4'h1) begin
			cnt_d = 4'h0;
			tgl_d = ~tgl_q;
			val_d = nxt;
			// Resync is tracked on every byte, whatever the core is doing.
			if (nxt == `RESYNC_FILL) begin
				if (fills_q != 5'h1f)
					fills_d = fills_q + 5'h01;
			end else begin
				if (nxt == `RESYNC_END && fills_q >= `RESYNC_MIN_FILLS)
					rtgl_d = ~rtgl_q;
				fills_d = 5'h00;
			end
		end
	end

	always_ff @(posedge sclk_in) begin
		if (!nrst_in) begin
			shift_q <= 8'h00;
			cnt_q   <= 4'h0;
			fills_q <= 5'h00;
			tgl_q   <= 1'b0;
			rtgl_q  <= 1'b0;
			val_q   <= 8'h00;
		end else begin
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			fills_q <= fills_d;
			tgl_q   <= tgl_d;
			rtgl_q  <= rtgl_d;
			val_q   <= val_d;
		end
	end

	assign lnk.byte_tgl   = tgl_q;
	assign lnk.byte_val   = val_q;
	assign lnk.resync_tgl = rtgl_q;
endmodule

// ---- tb/cmd_byte_checker.sv ----
// Port checker for the command byte decoder, attached by bind.
// Assumes cmd_decode_pkg is compiled first; it watches top-level ports only.
`timescale 1ns/1ps
module cmd_byte_checker
	import cmd_decode_pkg::*;
(
	input wire logic       clk_in,           // Core clock.
	input wire logic       nrst_in,          // Reset, active low.
	input wire logic       conv_done_in,     // Conversion finished.
	input wire logic [7:0] cmd_byte_out,     // Accepted byte.
	input wire logic       cmd_valid_out,    // Decode pulse.
	input wire op_kind_t   op_kind_out,      // Command class.
	input wire logic       multi_out,        // Continuous flag.
	input wire logic [2:0] setup_ptr_out,    // Setup pointer.
	input wire logic       read_out,         // Read direction.
	input wire logic       offset_array_out, // Offset array walk.
	input wire logic       cmd_mode_out,     // Waiting for a command.
	input wire logic       converting_out    // Conversion running.
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	wire [2:0] cc = cmd_byte_out[2:0];
	sequence s_conv_cmd; cmd_valid_out && cmd_byte_out[7]; endsequence
	sequence s_reg_cmd; cmd_valid_out && !cmd_byte_out[7]; endsequence
	a_type_split: assert property (s_reg_cmd |-> op_kind_out inside {OP_KIND_REG, OP_KIND_ARRAY})
		else $error("register byte not decoded as access");
	a_multi_flag: assert property (s_conv_cmd ##0 op_kind_out == OP_KIND_CONV |-> multi_out == cmd_byte_out[6])
		else $error("continuous flag mismatch");
	a_ptr_pick: assert property (s_conv_cmd |-> setup_ptr_out == cmd_byte_out[5:3])
		else $error("setup pointer mismatch");
	a_offset_walk: assert property (cmd_valid_out |-> offset_array_out == (cmd_byte_out[7:4] == 4'h4 && cc == 3'h1))
		else $error("offset array decode wrong");
	a_read_dir: assert property (s_reg_cmd |-> read_out == cmd_byte_out[3])
		else $error("access direction wrong");
	a_op_decode: assert property (s_conv_cmd |-> op_kind_out == (cc == 3'h0 ? OP_KIND_CONV : cc inside {3'h1, 3'h2, 3'h5, 3'h6} ? OP_KIND_CAL : OP_KIND_NONE))
		else $error("operation code decode wrong");
	// A reserved code still pulses but must leave the port idle for the next two cycles.
	a_reserved_idle: assert property (s_conv_cmd ##0 op_kind_out == OP_KIND_NONE |=> (cmd_mode_out && !converting_out) [*2])
		else $error("reserved code caused action");
	a_mode_only: assert property (cmd_valid_out |-> $past(cmd_mode_out))
		else $error("command decoded outside command mode");
	a_one_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
		else $error("decode pulse too long");
	a_single_end: assert property (converting_out && !multi_out && conv_done_in |-> ##[1:4] !converting_out)
		else $error("single conversion did not end");
endmodule

bind cmd_byte_decoder cmd_byte_checker chk (.clk_in, .nrst_in, .conv_done_in, .cmd_byte_out,
	.cmd_valid_out, .op_kind_out, .multi_out, .setup_ptr_out, .read_out, .offset_array_out,
	.cmd_mode_out, .converting_out);

// ---- tb/host_serial_model.sv ----
// Host microcontroller model: shifts bytes MSB first into the serial port.
// Assumes the device samples data on the rising serial clock edge.
`timescale 1ns/1ps
module host_serial_model (
	output logic sclk_out, // Serial clock, still between frames.
	output logic sdi_out   // Serial data towards the device.
);
	initial begin
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	task automatic send_bit(input logic b);
		sdi_out = b;
		#62.5 sclk_out = 1'b1;
		#62.5 sclk_out = 1'b0;
	endtask
	// The line is inverted after a byte so a stale level never passes for a held bit.
	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) send_bit(v[i]);
		sdi_out = ~v[0];
	endtask
	task automatic resync();
		repeat (15) send_byte(8'hff);
		send_byte(8'hfe);
	endtask
endmodule

// ---- tb/adc_command_byte_decoder_tb.sv ----
// Self-checking bench for the command byte decoder with a serial host model.
// Assumes the checker is bound separately and the package is compiled first.
`timescale 1ns/1ps
module adc_command_byte_decoder_tb;
	import cmd_decode_pkg::*;
	logic clk_in = 0, nrst_in = 0, data_done_in = 0, conv_done_in = 0;
	logic [7:0] cmd_byte_out, mb;
	logic [2:0] op_code_out, setup_ptr_out, reg_sel_out;
	logic [1:0] chan_sel_out;
	logic cmd_valid_out, multi_out, read_out, array_out, offset_array_out;
	logic cmd_mode_out, converting_out, sclk_in, sdi_in;
	op_kind_t op_kind_out;
	int err_total = 0, total_checks = 0;
	logic [7:0] exp_q[$];
	host_serial_model host (.sclk_out(sclk_in), .sdi_out(sdi_in));
	cmd_byte_decoder uut (.clk_in, .nrst_in, .sclk_in, .sdi_in, .data_done_in, .conv_done_in,
		.cmd_byte_out, .cmd_valid_out, .op_kind_out, .op_code_out, .multi_out, .setup_ptr_out,
		.chan_sel_out, .reg_sel_out, .read_out, .array_out, .offset_array_out, .cmd_mode_out,
		.converting_out);
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	function automatic op_kind_t kind_of(logic [7:0] b);
		if (!b[7]) return b[6] ? OP_KIND_ARRAY : OP_KIND_REG;
		case (b[2:0])
			3'h0: return OP_KIND_CONV;
			3'h1, 3'h2, 3'h5, 3'h6: return OP_KIND_CAL;
			default: return OP_KIND_NONE;
		endcase
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic finish_op(logic conv);
		if (conv) conv_done_in = 1'b1;
		else data_done_in = 1'b1;
		repeat (2) @(negedge clk_in);
		conv_done_in = 1'b0;
		data_done_in = 1'b0;
		repeat (6) @(negedge clk_in);
	endtask
	task automatic issue(logic [7:0] b);
		op_kind_t k;
		k = kind_of(b);
		exp_q.push_back(b);
		host.send_byte(b);
		repeat (8) @(negedge clk_in);
		if (k == OP_KIND_REG || k == OP_KIND_ARRAY) finish_op(1'b0);
		else if (k != OP_KIND_NONE && !b[6]) finish_op(1'b1);
		chk("mode", {7'h0, !(k == OP_KIND_CONV && b[6])}, {7'h0, cmd_mode_out});
		chk("busy", {7'h0, k == OP_KIND_CONV && b[6]}, {7'h0, converting_out});
	endtask
	always @(negedge clk_in) begin
		if (cmd_valid_out === 1'b1) begin
			if (exp_q.size() == 0) chk("pending", 8'h1, 8'h0);
			else begin
				mb = exp_q.pop_front();
				chk("byte", mb, cmd_byte_out);
				chk("kind", {5'h0, kind_of(mb)}, {5'h0, op_kind_out});
				if (mb[7]) chk("ptr", {5'h0, mb[5:3]}, {5'h0, setup_ptr_out});
				if (kind_of(mb) == OP_KIND_CONV) chk("multi", {7'h0, mb[6]}, {7'h0, multi_out});
				if (!mb[7]) chk("read", {7'h0, mb[3]}, {7'h0, read_out});
				if (mb[7]) chk("op", {5'h0, mb[2:0]}, {5'h0, op_code_out});
				if (!mb[7]) chk("chan", {6'h0, mb[5:4]}, {6'h0, chan_sel_out});
				if (!mb[7]) chk("regsel", {5'h0, mb[2:0]}, {5'h0, reg_sel_out});
				chk("array", {7'h0, !mb[7] && mb[6]}, {7'h0, array_out});
				chk("offset", {7'h0, mb[7:4] == 4'h4 && mb[2:0] == 3'h1}, {7'h0, offset_array_out});
			end
		end
	end
	initial begin
		repeat (40000) @(posedge clk_in);
		err_total++;
		stop_test();
	end
	initial begin
		int s;
		s = $urandom(72328);
		repeat (10) @(negedge clk_in);
		host.send_bit(1'b1);
		host.send_bit(1'b0);
		@(negedge clk_in) nrst_in = 1'b1;
		chk("mode", 8'h1, {7'h0, cmd_mode_out});
		chk("byte", 8'h0, cmd_byte_out);
		$display("test reset done");
		for (int i = 0; i < 8; i++) issue({2'b10, i[2:0], i[2:0]});
		issue(8'h49);
		issue(8'h41);
		for (int i = 0; i < 6; i++) issue({1'b0, 7'($urandom)});
		$display("test decode done");
		issue({2'b11, 3'($urandom), 3'h0});
		host.resync();
		repeat (8) @(negedge clk_in);
		chk("mode", 8'h1, {7'h0, cmd_mode_out});
		chk("busy", 8'h0, {7'h0, converting_out});
		host.resync();
		issue(8'h88);
		$display("test resync done");
		stop_test();
	end
endmodule
